/* File: compact_timer_consts.vh */
/*
 * Constants for the compact timer: register offsets, field positions,
 * reset values and clock-select codes.
 * Assumes inclusion by bare name from the timer design files.
 */
`ifndef COMPACT_TIMER_CONSTS_VH
`define COMPACT_TIMER_CONSTS_VH

// Wishbone byte offsets, one aligned word each
`define OFS_CONTROL_0 4'h0
`define OFS_CONTROL_1 4'h4
`define OFS_COUNT_LOW 4'h8
`define OFS_COUNT_HIGH 4'hc
// Bits 5:2 of the address select the word; low two bits ignored
`define OFS_CMPA_LOW 6'h10
`define OFS_CMPA_HIGH 6'h14

// Reset values
`define CONTROL_0_RESET 8'h00
`define CONTROL_1_RESET 8'h00

// Control 0 fields
`define C0_PAUSE 7
`define C0_CKSEL_HI 6
`define C0_CKSEL_LO 4
`define C0_ON 3
`define C0_PER_HI 2
`define C0_PER_LO 0

// Control 1 fields
`define C1_MODE_HI 7
`define C1_MODE_LO 6
`define C1_PIN_HI 5
`define C1_PIN_LO 4
`define C1_INIT 3
`define C1_POL 2
`define C1_SWAP 1
`define C1_CLRSEL 0

// Operating modes
`define MODE_COMPARE 2'h0
`define MODE_PWM 2'h2
`define MODE_TIMER 2'h3

// Clock select codes
`define CK_SYS_DIV4 3'h0
`define CK_SYS 3'h1
`define CK_HIGH_DIV16 3'h2
`define CK_HIGH_DIV64 3'h3
`define CK_SUB_A 3'h4
`define CK_SUB_B 3'h5
`define CK_EXT_RISE 3'h6
`define CK_EXT_FALL 3'h7

// Prescaler terminal counts
`define DIV4_LAST 6'h03
`define DIV16_LAST 6'h0f
`define DIV64_LAST 6'h3f

`endif

/* File: timer_tick_gen.v */
/*
 * Counter clock selection: turns the chosen source into a one-cycle
 * tick on clk_i.
 * Assumes high_clk_tick_i and sub_clk_tick_i are same-domain pulses and
 * the external count pin is asynchronous.
 */
`timescale 1ns/1ps
`default_nettype none
`include "compact_timer_consts.vh"

module timer_tick_gen (
    // Clock and reset
    input wire clk_i,
    input wire rst_i,
    // Selection
    input wire [2:0] clock_select_i,
    input wire run_i,
    // Sources
    input wire high_clk_tick_i,
    input wire sub_clk_tick_i,
    input wire external_count_pin_i,
    // Result
    output reg tick_o
);

////////////////////////////////////////////////////////////////////////
reg [5:0] sys_div_r;
reg [5:0] high_div_r;
reg ext_meta_r;
reg ext_sync_r;
reg ext_prev_r;
wire ext_rise;
wire ext_fall;

// Free-running prescalers; they keep running while off so restart is cheap
always @(posedge clk_i) begin
    if (rst_i) begin
        sys_div_r <= 6'h00;
        high_div_r <= 6'h00;
    end else begin
        sys_div_r <= (sys_div_r == `DIV4_LAST) ? 6'h00 : sys_div_r + 6'h01;
        if (high_clk_tick_i) begin
            high_div_r <= high_div_r + 6'h01;
        end
    end
end

// Two-stage synchroniser, then a separate edge history stage
always @(posedge clk_i) begin
    if (rst_i) begin
        ext_meta_r <= 1'b0;
        ext_sync_r <= 1'b0;
        ext_prev_r <= 1'b0;
    end else begin
        ext_meta_r <= external_count_pin_i;
        ext_sync_r <= ext_meta_r;
        ext_prev_r <= ext_sync_r;
    end
end

assign ext_rise = ext_sync_r & ~ext_prev_r;
assign ext_fall = ~ext_sync_r & ext_prev_r;

// Source multiplexer
always @* begin
    case (clock_select_i)
        `CK_SYS_DIV4: tick_o = run_i & (sys_div_r == `DIV4_LAST);
        `CK_SYS: tick_o = run_i;
        `CK_HIGH_DIV16: tick_o = run_i & high_clk_tick_i & (high_div_r[3:0] == `DIV16_LAST);
        `CK_HIGH_DIV64: tick_o = run_i & high_clk_tick_i & (high_div_r == `DIV64_LAST);
        `CK_SUB_A, `CK_SUB_B: tick_o = run_i & sub_clk_tick_i;
        `CK_EXT_RISE: tick_o = run_i & ext_rise;
        `CK_EXT_FALL: tick_o = run_i & ext_fall;
        default: tick_o = 1'b0;
    endcase
end

endmodule
`default_nettype wire

/* File: compact_timer_pwm.v */
/*
 * Compact 10-bit timer with compare-match output, PWM output and
 * timer/counter modes, reached over a classic Wishbone slave.
 * Assumes a single clk_i domain, synchronous active-high reset, and
 * clock-source ticks that are same-domain pulses except the count pin.
 */

`timescale 1ns/1ps
`default_nettype none
`include "compact_timer_consts.vh"

module compact_timer_pwm (
    // Clock and reset
    input wire clk_i,
    input wire rst_i,
    // Wishbone slave
    input wire cyc_i,
    input wire stb_i,
    input wire we_i,
    input wire [5:0] adr_i,
    input wire [3:0] sel_i,
    input wire [31:0] dat_i,
    output reg [31:0] dat_o,
    output wire ack_o,
    // Clock sources
    input wire high_clk_tick_i,
    input wire sub_clk_tick_i,
    input wire external_count_pin_i,
    // Timer outputs
    output reg primary_output_pin_o,
    output reg complement_output_pin_o,
    output reg period_match_o,
    output reg compare_a_match_o
);

////////////////////////////////////////////////////////////////////////
// Registers

// compare_a_r holds only committed values; a low byte from software
// waits in low_buffer_r until its high byte comes, so the comparator
// never sees a half-written pair.
reg [7:0] control_0_r;
reg [7:0] control_1_r;
reg [9:0] count_r;
reg [9:0] compare_a_r;
reg [7:0] low_buffer_r;
reg timer_on_prev_r;
reg out_level_r;
reg ack_r;

// Field views of the control registers; no logic here alters a
// control bit on its own, so software reads back what it wrote.
wire count_pause = control_0_r[`C0_PAUSE];
wire [2:0] clock_select = control_0_r[`C0_CKSEL_HI:`C0_CKSEL_LO];
wire timer_on = control_0_r[`C0_ON];
wire [2:0] period_compare = control_0_r[`C0_PER_HI:`C0_PER_LO];
wire [1:0] operating_mode_select = control_1_r[`C1_MODE_HI:`C1_MODE_LO];
wire [1:0] pin_action_select = control_1_r[`C1_PIN_HI:`C1_PIN_LO];
wire initial_level = control_1_r[`C1_INIT];
wire output_polarity = control_1_r[`C1_POL];
wire period_duty_swap = control_1_r[`C1_SWAP];
wire clear_source_select = control_1_r[`C1_CLRSEL];

////////////////////////////////////////////////////////////////////////
// Bus decode

// A request is taken while ack is low; ack then stands one cycle.
// Writes land on the edge at which the master samples ack high, so
// the register file and the master agree on when a write happened.
// Reads are captured one edge earlier so dat_o stands at that edge.
// A master that drops stb before ack loses its write.
wire bus_req = cyc_i & stb_i & ~ack_r;
wire wr_req = cyc_i & stb_i & ack_r & we_i & sel_i[0];
wire rd_req = bus_req & ~we_i;
wire [5:0] word_adr = {adr_i[5:2], 2'b00};
wire timer_on_rise = timer_on & ~timer_on_prev_r;

// One-wait-state ack, registered a cycle after the request, dropped the cycle after it is given
always @(posedge clk_i) begin
    if (rst_i) begin
        ack_r <= 1'b0;
    end else begin
        ack_r <= bus_req;
    end
end

assign ack_o = ack_r;

// Address compare shared by write and read paths
function is_reg;
    input [5:0] adr;
    input [5:0] ofs;
    begin
        is_reg = (adr == ofs);
    end
endfunction

////////////////////////////////////////////////////////////////////////
// Clock selection

// No tick on the cycle of a timer_on rise: that cycle clears the
// counter, and a tick there would be lost to the clear.
// Pause and off both withhold ticks, so the count simply holds.
wire count_tick;

timer_tick_gen u_tick (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .clock_select_i(clock_select),
    .run_i(timer_on & ~count_pause & ~timer_on_rise),
    .high_clk_tick_i(high_clk_tick_i),
    .sub_clk_tick_i(sub_clk_tick_i),
    .external_count_pin_i(external_count_pin_i),
    .tick_o(count_tick)
);

////////////////////////////////////////////////////////////////////////
// Comparators

// The period comparator looks at the value the tick would produce, so
// with the period clear selected the counter never shows code*128 and a
// period is exactly code*128 ticks, just as overflow gives 1024.
// Period code zero never matches the top bits, so overflow ends the period
wire [9:0] count_next = count_r + 10'h001;
wire period_hit = (period_compare != 3'h0) & (count_next[9:7] == period_compare);

// Compare A matches the value that stands; an A period is value+1 ticks
wire a_hit = (count_r == compare_a_r);
wire overflow = (count_r == 10'h3ff) & count_tick;
wire period_match_ev = count_tick & (period_hit & (count_next[6:0] == 7'h00));
wire a_match_ev = count_tick & a_hit;
wire clear_on_match = clear_source_select ? a_match_ev : period_match_ev;

// Event flags to the surrounding logic
// One-cycle pulses, registered alongside out_level_r; the pin registers follow one cycle later.
// Overflow raises the period flag only when the period code is zero.
always @(posedge clk_i) begin
    if (rst_i) begin
        period_match_o <= 1'b0;
        compare_a_match_o <= 1'b0;
    end else begin
        period_match_o <= period_match_ev | (overflow & (period_compare == 3'h0));
        compare_a_match_o <= a_match_ev;
    end
end

////////////////////////////////////////////////////////////////////////
// Counter

// The match is seen on the tick that reaches the value, then cleared
// A timer_on rise wins over any tick, and a clear beats the increment.
// There is no bus path into count_r at all.
always @(posedge clk_i) begin
    if (rst_i) begin
        count_r <= 10'h000;
        timer_on_prev_r <= 1'b0;
    end else begin
        timer_on_prev_r <= timer_on;
        if (timer_on_rise) begin
            count_r <= 10'h000;
        end else if (count_tick) begin
            if (clear_on_match | overflow) begin
                count_r <= 10'h000;
            end else begin
                count_r <= count_next;
            end
        end
    end
end

////////////////////////////////////////////////////////////////////////
// Register writes

// A low-byte write only fills the buffer; the high byte commits it
// Writes with sel_i[0] low are dropped; only lane 0 carries data.
// A high-byte read copies the matching low byte into the buffer, so
// the low read that follows belongs to the same running count.
always @(posedge clk_i) begin
    if (rst_i) begin
        control_0_r <= `CONTROL_0_RESET;
        control_1_r <= `CONTROL_1_RESET;
        compare_a_r <= 10'h000;
        low_buffer_r <= 8'h00;
    end else begin
        if (wr_req & is_reg(word_adr, {2'b00, `OFS_CONTROL_0})) begin
            control_0_r <= dat_i[7:0];
        end
        if (wr_req & is_reg(word_adr, {2'b00, `OFS_CONTROL_1})) begin
            control_1_r <= dat_i[7:0];
        end
        if (wr_req & is_reg(word_adr, `OFS_CMPA_LOW)) begin
            low_buffer_r <= dat_i[7:0];
        end else if (wr_req & is_reg(word_adr, `OFS_CMPA_HIGH)) begin
            compare_a_r <= {dat_i[1:0], low_buffer_r};
        end else if (rd_req & is_reg(word_adr, `OFS_CMPA_HIGH)) begin
            low_buffer_r <= compare_a_r[7:0];
        end else if (rd_req & is_reg(word_adr, {2'b00, `OFS_COUNT_HIGH})) begin
            low_buffer_r <= count_r[7:0];
        end
    end
end

////////////////////////////////////////////////////////////////////////
// Register reads

// Both low bytes read the shared buffer; unmapped words read zero
// Read the high byte first, or the low read returns what was left.
always @(posedge clk_i) begin
    if (rst_i) begin
        dat_o <= 32'h0000_0000;
    end else if (rd_req) begin
        if (is_reg(word_adr, {2'b00, `OFS_CONTROL_0})) begin
            dat_o <= {24'h000000, control_0_r};
        end else if (is_reg(word_adr, {2'b00, `OFS_CONTROL_1})) begin
            dat_o <= {24'h000000, control_1_r};
        end else if (is_reg(word_adr, {2'b00, `OFS_COUNT_LOW}) | is_reg(word_adr, `OFS_CMPA_LOW)) begin
            dat_o <= {24'h000000, low_buffer_r};
        end else if (is_reg(word_adr, {2'b00, `OFS_COUNT_HIGH})) begin
            dat_o <= {30'h0, count_r[9:8]};
        end else if (is_reg(word_adr, `OFS_CMPA_HIGH)) begin
            dat_o <= {30'h0, compare_a_r[9:8]};
        end else begin
            dat_o <= 32'h0000_0000;
        end
    end
end

////////////////////////////////////////////////////////////////////////
// Output stage

// PWM: which comparator bounds the period and which the duty
wire period_end = period_duty_swap ? a_match_ev : (period_match_ev | overflow);
wire duty_end = period_duty_swap ? period_match_ev : a_match_ev;
wire mode_cmp = (operating_mode_select == `MODE_COMPARE);
wire mode_pwm = (operating_mode_select == `MODE_PWM);

// Mode 01 and timer mode leave the level alone
// Forced PWM levels refresh every cycle; the waveform moves at events.
always @(posedge clk_i) begin
    if (rst_i) begin
        out_level_r <= 1'b0;
    end else if (timer_on_rise & (mode_cmp | mode_pwm)) begin
        out_level_r <= initial_level;
    end else if (mode_cmp & a_match_ev) begin
        case (pin_action_select)
            2'h1: out_level_r <= 1'b0;
            2'h2: out_level_r <= 1'b1;
            2'h3: out_level_r <= ~out_level_r;
            default: out_level_r <= out_level_r;
        endcase
    end else if (mode_pwm) begin
        // Active level for the duty part, inactive after it
        case (pin_action_select)
            2'h0: out_level_r <= ~initial_level;
            2'h1: out_level_r <= initial_level;
            2'h2: begin
                if (duty_end) begin
                    out_level_r <= ~initial_level;
                end else if (period_end) begin
                    out_level_r <= initial_level;
                end
            end
            default: out_level_r <= out_level_r;
        endcase
    end
end

// Pin drive; timer mode ignores polarity, its level is unspecified
// The complement pin never takes polarity; it carries the inverted level.
always @(posedge clk_i) begin
    if (rst_i) begin
        primary_output_pin_o <= 1'b0;
        complement_output_pin_o <= 1'b1;
    end else if (operating_mode_select == `MODE_TIMER) begin
        primary_output_pin_o <= out_level_r;
        complement_output_pin_o <= ~out_level_r;
    end else begin
        primary_output_pin_o <= out_level_r ^ output_polarity;
        complement_output_pin_o <= ~out_level_r;
    end
end

endmodule
`default_nettype wire

/* File: compact_timer_pwm_sva.sv */
/* Checker for compact_timer_pwm: bus handshake, match pulses, pin levels.
   Assumes it is bound to the timer top and sees only its ports. */
`timescale 1ns/1ps
`default_nettype none
module compact_timer_pwm_sva (
    // Clock and reset
    input wire clk_i,
    input wire rst_i,
    // Bus
    input wire cyc_i,
    input wire stb_i,
    input wire we_i,
    input wire [5:0] adr_i,
    input wire [3:0] sel_i,
    input wire [31:0] dat_i,
    input wire ack_o,
    // Timer outputs
    input wire primary_output_pin_o,
    input wire complement_output_pin_o,
    input wire period_match_o,
    input wire compare_a_match_o
);
    logic [7:0] c0_r;
    logic [7:0] c1_r;
    logic [1:0] quiet_r;
    logic [10:0] gap_r;
    logic clean_r;
    wire wr_ok = ack_o && cyc_i && stb_i && we_i && sel_i[0];
    wire wr0 = wr_ok && adr_i[5:2] == 4'h0;
    wire wr1 = wr_ok && adr_i[5:2] == 4'h1;
    wire pol_on = c1_r[2] && c1_r[7:6] != 2'h3;
    ////////////////////////////////////////////////////////////
    // Shadow registers load on the same edge as the block, but the pins lag, so pin checks wait for quiet_r
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            c0_r <= 8'h00;
            c1_r <= 8'h00;
            quiet_r <= 2'h0;
            gap_r <= 11'h000;
            clean_r <= 1'b0;
        end else begin
            if (wr0) c0_r <= dat_i[7:0];
            if (wr1) c1_r <= dat_i[7:0];
            quiet_r <= wr1 ? 2'h0 : (quiet_r == 2'h3 ? 2'h3 : quiet_r + 2'h1);
            gap_r <= period_match_o ? 11'h001 : gap_r + 11'h001;
            clean_r <= wr0 ? 1'b0 : (period_match_o ? 1'b1 : clean_r);
        end
    end
    ////////////////////////////////////////////////////////////
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    chk_ack_follows: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("no ack after request");
    chk_ack_single: assert property (ack_o |=> !ack_o)
        else $error("ack longer than one cycle");
    chk_ack_cause: assert property (ack_o |-> $past(cyc_i && stb_i))
        else $error("ack without request");
    chk_per_pulse: assert property (period_match_o |=> !period_match_o)
        else $error("period match pulse too long");
    chk_cmpa_pulse: assert property (compare_a_match_o |=> !compare_a_match_o)
        else $error("compare A pulse too long");
    chk_low_action: assert property (compare_a_match_o && quiet_r == 2'h3 && c1_r[7:4] == 4'h1
        |-> ##1 primary_output_pin_o == c1_r[2]) else $error("match did not drive low");
    chk_high_action: assert property (compare_a_match_o && quiet_r == 2'h3 && c1_r[7:4] == 4'h2
        |-> ##1 primary_output_pin_o == !c1_r[2]) else $error("match did not drive high");
    chk_pin_pair: assert property (quiet_r == 2'h3
        |-> primary_output_pin_o == (!complement_output_pin_o ^ pol_on)) else $error("pin pair wrong");
    chk_ovf_gap: assert property (period_match_o && clean_r && c0_r == 8'h18
        |-> gap_r == 11'd1024) else $error("overflow period wrong");
endmodule
bind compact_timer_pwm compact_timer_pwm_sva chk_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .ack_o(ack_o),
    .primary_output_pin_o(primary_output_pin_o), .complement_output_pin_o(complement_output_pin_o),
    .period_match_o(period_match_o), .compare_a_match_o(compare_a_match_o));
`default_nettype wire

/* File: tb_top.sv */
/* Self-checking bench for compact_timer_pwm, one task per scenario.
   Assumes the checker file is compiled too and binds itself. */
`timescale 1ns/1ps
`default_nettype none
`include "compact_timer_consts.vh"
module tb_top;
    localparam [5:0] A_C0 = {2'b00, `OFS_CONTROL_0};
    localparam [5:0] A_C1 = {2'b00, `OFS_CONTROL_1};
    localparam [5:0] A_LO = {2'b00, `OFS_COUNT_LOW};
    localparam [5:0] A_HI = {2'b00, `OFS_COUNT_HIGH};
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc_i = 1'b0;
    logic stb_i = 1'b0;
    logic we_i = 1'b0;
    logic [5:0] adr_i = 6'h00;
    logic [31:0] dat_i = 32'h0;
    logic ext_i = 1'b0;
    wire [31:0] dat_o;
    wire ack_o;
    wire pin_o;
    wire pinb_o;
    wire per_o;
    wire cmp_o;
    logic [7:0] q;
    logic [9:0] c;
    logic [9:0] c2;
    integer n_fail = 0;
    integer cmp_count = 0;
    integer n;
    integer k;
    // Fast ticks are held high so every prescaler input is live
    compact_timer_pwm DUT (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
        .adr_i(adr_i), .sel_i(4'hf), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .high_clk_tick_i(1'b1),
        .sub_clk_tick_i(1'b1), .external_count_pin_i(ext_i), .primary_output_pin_o(pin_o),
        .complement_output_pin_o(pinb_o), .period_match_o(per_o), .compare_a_match_o(cmp_o));
    // 40 MHz clock
    initial begin
        forever #12.5 clk_i = ~clk_i;
    end
    ////////////////////////////////////////////////////////////
    // Verdict and the only exit
    task test_done;
        begin
            $display("compares %0d mismatches %0d", cmp_count, n_fail);
            if (n_fail == 0 && cmp_count > 0) $display("TB: PASS");
            else $display("TB: FAIL");
            $finish;
        end
    endtask
    // Case-equal compare so unknowns never match
    task chk(input [31:0] seen, input [31:0] exp, input [8*6:1] what);
        begin
            cmp_count = cmp_count + 1;
            if (seen !== exp) begin
                n_fail = n_fail + 1;
                $display("BAD %0s exp %0h seen %0h", what, exp, seen);
            end
        end
    endtask
    // Classic cycle: request held until ack is sampled high, then one idle cycle
    task bus(input w, input [5:0] a, input [7:0] d);
        integer i;
        begin
            cyc_i <= 1'b1;
            stb_i <= 1'b1;
            we_i <= w;
            adr_i <= a;
            dat_i <= {24'h0, d};
            i = 0;
            do begin
                @(posedge clk_i);
                i = i + 1;
            end while (ack_o !== 1'b1 && i < 20);
            if (ack_o !== 1'b1) begin
                n_fail = n_fail + 1;
                test_done;
            end
            q = dat_o[7:0];
            cyc_i <= 1'b0;
            stb_i <= 1'b0;
            @(posedge clk_i);
        end
    endtask
    // High byte first so the low byte is captured alongside
    task rdcnt;
        begin
            bus(1'b0, A_HI, 8'h00);
            c[9:8] = q[1:0];
            bus(1'b0, A_LO, 8'h00);
            c[7:0] = q;
        end
    endtask
    // Off then on, so timer_on sees a rising edge
    task restart(input [7:0] v);
        begin
            bus(1'b1, A_C0, 8'h00);
            bus(1'b1, A_C0, v);
        end
    endtask
    // Mode and pin action only change while the timer is off
    task set_c1(input [7:0] v);
        begin
            bus(1'b1, A_C0, 8'h00);
            bus(1'b1, A_C1, v);
        end
    endtask
    // Cycles to the next match pulse; bounded so a dead timer ends the run
    task wait_ev(input s);
        begin
            n = 0;
            do begin
                @(posedge clk_i);
                n = n + 1;
            end while ((s ? cmp_o : per_o) !== 1'b1 && n < 3000);
            if (n >= 3000) begin
                n_fail = n_fail + 1;
                test_done;
            end
        end
    endtask
    // Compare A pair write; low byte only lands with the high byte
    task set_a(input [9:0] v);
        begin
            bus(1'b1, `OFS_CMPA_LOW, v[7:0]);
            bus(1'b1, `OFS_CMPA_HIGH, {6'h00, v[9:8]});
        end
    endtask
    ////////////////////////////////////////////////////////////
    // Control 0 reset value, read-back, unmapped word and the low-byte buffer
    task t_regs;
        begin
            bus(1'b0, A_C0, 8'h00);
            chk(q, 8'h00, "ctl0");
            bus(1'b1, A_C1, 8'h5a);
            bus(1'b0, A_C1, 8'h00);
            chk(q, 8'h5a, "ctl1");
            bus(1'b1, 6'h18, 8'h77);
            bus(1'b0, 6'h18, 8'h00);
            chk(q, 8'h00, "unmap");
            set_a(10'h23c);
            bus(1'b1, `OFS_CMPA_LOW, 8'h99);
            bus(1'b0, `OFS_CMPA_HIGH, 8'h00);
            chk(q, 8'h02, "cmpah");
            bus(1'b0, `OFS_CMPA_LOW, 8'h00);
            chk(q, 8'h3c, "cmpal");
        end
    endtask
    // Each clock source; prescaler phase allows a small slack
    task t_clock;
        integer e;
        begin
            for (k = 0; k < 8; k = k + 1) begin
                restart({1'b0, k[2:0], 4'h8});
                if (k < 6) repeat (256) @(posedge clk_i);
                else repeat (5) begin
                    repeat (4) @(posedge clk_i);
                    ext_i <= 1'b1;
                    repeat (4) @(posedge clk_i);
                    ext_i <= 1'b0;
                end
                repeat (6) @(posedge clk_i);
                rdcnt;
                e = (k == 0) ? 64 : (k == 2) ? 16 : (k == 3) ? 4 : (k > 5) ? 5 : 256;
                if (k > 5) chk(c, e, "edges");
                else chk(c + 1 >= e && c <= e + 8, 1, "rate");
            end
        end
    endtask
    // Pause, stop, read-only count and clear on restart
    task t_run;
        begin
            restart(8'h18);
            repeat (40) @(posedge clk_i);
            bus(1'b1, A_C0, 8'h98);
            rdcnt;
            c2 = c;
            repeat (30) @(posedge clk_i);
            rdcnt;
            chk(c, c2, "pause");
            bus(1'b1, A_C0, 8'h18);
            repeat (30) @(posedge clk_i);
            rdcnt;
            chk(c > c2 + 30, 1, "resume");
            bus(1'b1, A_C0, 8'h10);
            rdcnt;
            c2 = c;
            bus(1'b1, A_HI, 8'h03);
            bus(1'b1, A_LO, 8'hff);
            rdcnt;
            chk(c, c2, "held");
            bus(1'b1, A_C0, 8'h18);
            rdcnt;
            chk(c < 10, 1, "clear");
        end
    endtask
    // Overflow, period code 3, and clearing on compare A
    task t_period;
        begin
            set_c1(8'h00);
            restart(8'h18);
            wait_ev(1'b0);
            wait_ev(1'b0);
            chk(n, 1024, "ovf");
            restart(8'h1b);
            wait_ev(1'b0);
            wait_ev(1'b0);
            chk(n, 384, "per3");
            set_a(10'd100);
            set_c1(8'h01);
            restart(8'h1b);
            wait_ev(1'b1);
            wait_ev(1'b1);
            chk(n == 100 || n == 101, 1, "clra");
        end
    endtask
    // Every pin action in compare mode, initial level high
    task t_cmp;
        begin
            for (k = 0; k < 4; k = k + 1) begin
                set_c1({2'b00, k[1:0], 4'h9});
                restart(8'h18);
                repeat (2) @(posedge clk_i);
                chk(pin_o, 1, "init");
                wait_ev(1'b1);
                repeat (2) @(posedge clk_i);
                chk(pin_o, !k[0], "act");
                chk(pinb_o, k[0], "cpl");
            end
        end
    endtask
    // Forced PWM levels with polarity, then duty of the waveform
    task t_pwm;
        begin
            for (k = 0; k < 4; k = k + 1) begin
                set_c1({3'b100, k[0], 1'b1, k[1], 2'b00});
                restart(8'h19);
                repeat (3) @(posedge clk_i);
                chk(pin_o, k[0] ^ k[1], "force");
                chk(pinb_o, !k[0], "cplf");
            end
            set_c1(8'hc4);
            repeat (3) @(posedge clk_i);
            chk(pin_o ^ pinb_o, 1, "tmr");
            set_a(10'd32);
            set_c1(8'ha8);
            restart(8'h19);
            wait_ev(1'b0);
            c2 = 0;
            repeat (128) begin
                @(posedge clk_i);
                c2 = c2 + pin_o;
            end
            chk(c2 >= 31 && c2 <= 34, 1, "duty");
            // Swapped roles: A bounds the period, the period code the duty
            set_a(10'd200);
            set_c1(8'hab);
            restart(8'h19);
            wait_ev(1'b1);
            c2 = 0;
            repeat (201) begin
                @(posedge clk_i);
                c2 = c2 + pin_o;
            end
            chk(c2 >= 127 && c2 <= 130, 1, "swap");
        end
    endtask
    ////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        t_regs;
        t_clock;
        t_run;
        t_period;
        t_cmp;
        t_pwm;
        test_done;
    end
endmodule
`default_nettype wire
